//--- srd_pkg.sv
// Purpose: shared constants and types for the serial word deframer.
// Assumes: 125 MHz reference clock, link bit clock from the bit-rate PLL.
// Notes: word clock counts derived from times and the reference clock period.

package srd_pkg;

   localparam int unsigned DATA_BITS = 10;
   localparam int unsigned FRAME_BITS = 12;
   localparam logic [3:0] LAST_POS = 4'hB;
   localparam logic [11:0] CAND_ALL = 12'hFFF;
   localparam int unsigned DATA_LSB = 1;
   localparam int unsigned DATA_MSB = 10;

   // reference settle time, in reference cycles
   localparam logic [11:0] PLL_REF_LOCK_CYCLES = 12'h800;

   // local word clock used while not locked to the serial stream
   localparam int unsigned REF_CLK_NS = 8;
   localparam int unsigned LOCAL_WORD_NS = 144;
   localparam logic [4:0] WORD_CYC = 5'(LOCAL_WORD_NS / REF_CLK_NS);
   localparam logic [4:0] HALF_CYC = 5'(LOCAL_WORD_NS / REF_CLK_NS / 2);

   // least recovered clock cycles the lock indicator stays high
   localparam logic [1:0] LOCK_HOLD_RCLKS = 2'h2;

   // positions in the reference-domain synchroniser bundle
   localparam int unsigned SY_SEL = 0;
   localparam int unsigned SY_REN = 1;
   localparam int unsigned SY_LOCK = 2;
   localparam int unsigned SY_WORD = 3;
   localparam int unsigned SYNC_W = 4;

   typedef enum logic [1:0] {
      SRD_HUNT,
      SRD_CONFIRM,
      SRD_LOCKED
   } srd_hunt_t;

endpackage

//--- srd_deframer.sv
// Purpose: link-side frame hunt, lock and word extraction on the bit clock.
// Assumes: bit_clk_in samples one serial bit per rising edge.
// Notes: word and toggle are stable for a full frame after each toggle.
`timescale 1ns/100ps

module srd_deframer (
   input wire logic bit_clk_in,
   input wire logic rstn_in,
   input wire logic ref_ready_in,
   input wire logic serial_in_pos_in,
   input wire logic serial_in_neg_in,
   output logic [9:0] word_out,
   output logic word_toggle_out,
   output logic locked_out
);

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [3:0] prev_pos(input logic [3:0] p);
      prev_pos = (p == 4'h0) ? srd_pkg::LAST_POS : p - 4'h1;
   endfunction

   function automatic logic one_hot(input logic [11:0] c);
      one_hot = (c != 12'h000) && ((c & (c - 12'h001)) == 12'h000);
   endfunction

   function automatic logic [3:0] hot_index(input logic [11:0] c);
      hot_index = 4'h0;
      for (int i = 0; i < srd_pkg::FRAME_BITS; i++) begin
         if (c[i]) begin
            hot_index = 4'(i);
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   logic rst_meta;
   logic link_rstn;
   logic [2:0] in_meta;
   logic [2:0] in_sync;
   logic prev_bit;
   logic [3:0] pos_cnt;
   logic [11:0] sr;
   logic [11:0] cand;
   logic [11:0] next_cand;
   logic [3:0] align;
   srd_pkg::srd_hunt_t state;
   logic bit_now;
   logic rising;
   logic [11:0] next_sr;

   // release of the link reset is timed to this clock
   always_ff @(posedge bit_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_meta <= 1'b0;
         link_rstn <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         link_rstn <= rst_meta;
      end
   end

   always_ff @(posedge bit_clk_in or negedge link_rstn) begin
      if (!link_rstn) begin
         in_meta <= 3'h0;
         in_sync <= 3'h0;
      end else begin
         in_meta <= {ref_ready_in, serial_in_neg_in, serial_in_pos_in};
         in_sync <= in_meta;
      end
   end

   assign bit_now = in_sync[0] & ~in_sync[1];
   assign rising = bit_now & ~prev_bit;
   assign next_sr = {bit_now, sr[11:1]};

   always_comb begin
      next_cand = cand;
      if (!rising) begin
         next_cand[pos_cnt] = 1'b0;
      end
   end

   // twelve bits per word: bit rate tracks the word clock
   always_ff @(posedge bit_clk_in or negedge link_rstn) begin
      if (!link_rstn) begin
         pos_cnt <= 4'h0;
         prev_bit <= 1'b0;
         sr <= 12'h000;
      end else begin
         pos_cnt <= (pos_cnt == srd_pkg::LAST_POS) ? 4'h0 : pos_cnt + 4'h1;
         prev_bit <= bit_now;
         sr <= next_sr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // a data edge that repeats at one position every frame is never
   // eliminated; only sync frames guarantee a single survivor
   always_ff @(posedge bit_clk_in or negedge link_rstn) begin
      if (!link_rstn) begin
         state <= srd_pkg::SRD_HUNT;
         cand <= srd_pkg::CAND_ALL;
         align <= 4'h0;
      end else if (!in_sync[2]) begin
         state <= srd_pkg::SRD_HUNT;
         cand <= srd_pkg::CAND_ALL;
      end else begin
         case (state)
            srd_pkg::SRD_HUNT: begin
               if (pos_cnt == srd_pkg::LAST_POS) begin
                  cand <= srd_pkg::CAND_ALL;
                  if (one_hot(next_cand)) begin
                     state <= srd_pkg::SRD_CONFIRM;
                     align <= hot_index(next_cand);
                  end else if (next_cand != 12'h000) begin
                     cand <= next_cand;
                  end
               end else begin
                  cand <= next_cand;
               end
            end
            srd_pkg::SRD_CONFIRM: begin
               if (pos_cnt == align) begin
                  state <= rising ? srd_pkg::SRD_LOCKED
                                  : srd_pkg::SRD_HUNT;
               end
            end
            srd_pkg::SRD_LOCKED: begin
               if (pos_cnt == align && !rising) begin
                  state <= srd_pkg::SRD_HUNT;
               end
            end
            default: begin
               state <= srd_pkg::SRD_HUNT;
            end
         endcase
      end
   end

   // word taken at the end bit: start and end bits dropped
   always_ff @(posedge bit_clk_in or negedge link_rstn) begin
      if (!link_rstn) begin
         word_out <= 10'h000;
         word_toggle_out <= 1'b0;
         locked_out <= 1'b0;
      end else begin
         locked_out <= (state == srd_pkg::SRD_LOCKED);
         if (state == srd_pkg::SRD_LOCKED && pos_cnt == prev_pos(align)) begin
            word_out <= next_sr[srd_pkg::DATA_MSB:srd_pkg::DATA_LSB];
            word_toggle_out <= ~word_toggle_out;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   relock_two_a: assert property (
      @(posedge bit_clk_in) disable iff (!link_rstn)
      $rose(state == srd_pkg::SRD_LOCKED) |->
         $past(state == srd_pkg::SRD_CONFIRM) && $past(rising))
      else $error("lock taken without a confirming boundary edge");

   miss_unlock_a: assert property (
      @(posedge bit_clk_in) disable iff (!link_rstn)
      in_sync[2] && state == srd_pkg::SRD_LOCKED && pos_cnt == align
         && !rising |=> state == srd_pkg::SRD_HUNT ##1 !locked_out)
      else $error("missed boundary edge did not drop lock");

endmodule // srd_deframer

//--- srd_top.sv
// Purpose: deserialiser back end: word output, recovered clock, lock flag.
// Assumes: bit_clk_in is the bit-rate clock; ref_clk_in is 125 MHz.
// Notes: sleep_n_in low acts as an asynchronous reset of both domains.
`timescale 1ns/100ps

module srd_top (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic sleep_n_in,
   input wire logic bit_clk_in,
   input wire logic serial_in_pos_in,
   input wire logic serial_in_neg_in,
   input wire logic strobe_rise_sel_in,
   input wire logic out_enable_in,
   output logic [9:0] parallel_word_out,
   output logic parallel_word_oe_out,
   output logic recovered_clk_out,
   output logic recovered_clk_oe_out,
   output logic lock_n_out,
   output logic lock_n_oe_out
);

   ////////////////////////////////////////////////////////////////////////
   logic core_rstn;
   logic rst_meta;
   logic ref_rstn;
   logic [srd_pkg::SYNC_W-1:0] sy_raw;
   logic [srd_pkg::SYNC_W-1:0] sy_meta;
   logic [srd_pkg::SYNC_W-1:0] sy_sync;
   logic word_tgl_d;
   logic word_evt;
   logic [9:0] link_word;
   logic link_word_tgl;
   logic link_locked;
   logic [11:0] pll_cnt;
   logic ref_ready;
   logic serial_lock;
   logic follow_tx;
   logic [4:0] div_cnt;
   logic local_tick;
   logic tick;
   logic [4:0] half_cnt;
   logic fall_pulse;
   logic strobe;
   logic [9:0] cap_word;
   logic [1:0] hold_cnt;

   // sleep release and power-up both restart everything
   assign core_rstn = rstn_in & sleep_n_in;

   always_ff @(posedge ref_clk_in or negedge core_rstn) begin
      if (!core_rstn) begin
         rst_meta <= 1'b0;
         ref_rstn <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         ref_rstn <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // link side

   srd_deframer i_srd_deframer (
      .bit_clk_in(bit_clk_in),
      .rstn_in(core_rstn),
      .ref_ready_in(ref_ready),
      .serial_in_pos_in(serial_in_pos_in),
      .serial_in_neg_in(serial_in_neg_in),
      .word_out(link_word),
      .word_toggle_out(link_word_tgl),
      .locked_out(link_locked)
   );

   ////////////////////////////////////////////////////////////////////////
   // two-flop synchronisers for pins and link levels

   assign sy_raw[srd_pkg::SY_SEL] = strobe_rise_sel_in;
   assign sy_raw[srd_pkg::SY_REN] = out_enable_in;
   assign sy_raw[srd_pkg::SY_LOCK] = link_locked;
   assign sy_raw[srd_pkg::SY_WORD] = link_word_tgl;

   for (genvar g = 0; g < srd_pkg::SYNC_W; g++) begin : g_sync
      always_ff @(posedge ref_clk_in or negedge ref_rstn) begin
         if (!ref_rstn) begin
            sy_meta[g] <= 1'b0;
            sy_sync[g] <= 1'b0;
         end else begin
            sy_meta[g] <= sy_raw[g];
            sy_sync[g] <= sy_meta[g];
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge ref_rstn) begin
      if (!ref_rstn) begin
         word_tgl_d <= 1'b0;
      end else begin
         word_tgl_d <= sy_sync[srd_pkg::SY_WORD];
      end
   end

   // toggle crossing: the link word changed with the toggle and is steady for a frame
   assign word_evt = sy_sync[srd_pkg::SY_WORD] ^ word_tgl_d;

   ////////////////////////////////////////////////////////////////////////
   // settle on the local reference before link hunt, lock and data/clock enables; the local divider runs from reset

   always_ff @(posedge ref_clk_in or negedge ref_rstn) begin
      if (!ref_rstn) begin
         pll_cnt <= 12'h000;
         ref_ready <= 1'b0;
      end else if (!ref_ready) begin
         pll_cnt <= pll_cnt + 12'h001;
         ref_ready <= (pll_cnt == srd_pkg::PLL_REF_LOCK_CYCLES - 12'h001);
      end
   end

   assign serial_lock = sy_sync[srd_pkg::SY_LOCK] & ref_ready;

   ////////////////////////////////////////////////////////////////////////
   // recovered clock: local divider, or word events once locked

   assign follow_tx = ~lock_n_out;
   assign local_tick = (div_cnt == srd_pkg::WORD_CYC - 5'h01);
   assign tick = follow_tx ? word_evt : local_tick;

   always_ff @(posedge ref_clk_in or negedge ref_rstn) begin
      if (!ref_rstn) begin
         div_cnt <= 5'h00;
      end else if (follow_tx || local_tick) begin
         div_cnt <= 5'h00;
      end else begin
         div_cnt <= div_cnt + 5'h01;
      end
   end

   assign fall_pulse = recovered_clk_out &&
                       (half_cnt == srd_pkg::HALF_CYC - 5'h01);

   always_ff @(posedge ref_clk_in or negedge ref_rstn) begin
      if (!ref_rstn) begin
         recovered_clk_out <= 1'b0;
         half_cnt <= 5'h00;
      end else if (tick) begin
         recovered_clk_out <= 1'b1;
         half_cnt <= 5'h00;
      end else if (fall_pulse) begin
         recovered_clk_out <= 1'b0;
      end else if (recovered_clk_out) begin
         half_cnt <= half_cnt + 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // word output on the selected recovered clock edge

   // tick raises the clock next edge, fall_pulse lowers it; an edge
   // swallowed by a colliding tick presents nothing, so data never moves
   // without the selected clock edge
   assign strobe = sy_sync[srd_pkg::SY_SEL] ? (tick & ~recovered_clk_out)
                                            : (fall_pulse & ~tick);

   always_ff @(posedge ref_clk_in or negedge ref_rstn) begin
      if (!ref_rstn) begin
         cap_word <= 10'h000;
      end else if (word_evt) begin
         cap_word <= link_word;
      end
   end

   // a rising-edge strobe shows the previous word: a one-word lag that
   // keeps data steady around the falling clock edge
   always_ff @(posedge ref_clk_in or negedge ref_rstn) begin
      if (!ref_rstn) begin
         parallel_word_out <= 10'h000;
      end else if (strobe) begin
         parallel_word_out <= cap_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // lock indicator with a minimum high time after any loss

   always_ff @(posedge ref_clk_in or negedge ref_rstn) begin
      if (!ref_rstn) begin
         hold_cnt <= 2'h0;
      end else if (!lock_n_out) begin
         hold_cnt <= 2'h0;
      end else if (tick && hold_cnt != srd_pkg::LOCK_HOLD_RCLKS) begin
         hold_cnt <= hold_cnt + 2'h1;
      end
   end

   always_ff @(posedge ref_clk_in or negedge ref_rstn) begin
      if (!ref_rstn) begin
         lock_n_out <= 1'b1;
      end else if (!serial_lock) begin
         lock_n_out <= 1'b1;
      end else if (hold_cnt == srd_pkg::LOCK_HOLD_RCLKS) begin
         lock_n_out <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output enables: only the drivers, never the timing

   always_ff @(posedge ref_clk_in or negedge ref_rstn) begin
      if (!ref_rstn) begin
         parallel_word_oe_out <= 1'b0;
         recovered_clk_oe_out <= 1'b0;
         lock_n_oe_out <= 1'b0;
      end else begin
         parallel_word_oe_out <= ref_ready & sy_sync[srd_pkg::SY_REN];
         recovered_clk_oe_out <= ref_ready & sy_sync[srd_pkg::SY_REN];
         lock_n_oe_out <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   init_float_a: assert property (
      @(posedge ref_clk_in) disable iff (!ref_rstn)
      !ref_ready |=> !parallel_word_oe_out && !recovered_clk_oe_out
                     && lock_n_out)
      else $error("outputs active before reference settle");

   settle_time_a: assert property (
      @(posedge ref_clk_in) disable iff (!ref_rstn)
      $rose(ref_ready) |-> $past(pll_cnt) == srd_pkg::PLL_REF_LOCK_CYCLES
                          - 12'h001)
      else $error("reference settle count wrong");

   enable_gate_a: assert property (
      @(posedge ref_clk_in) disable iff (!ref_rstn)
      ref_ready ##1 ref_ready |->
         parallel_word_oe_out == $past(sy_sync[srd_pkg::SY_REN])
         && recovered_clk_oe_out == parallel_word_oe_out)
      else $error("data or clock enable does not follow enable pin");

   lock_drives_a: assert property (
      @(posedge ref_clk_in) disable iff (!ref_rstn)
      lock_n_oe_out |=> lock_n_oe_out)
      else $error("lock indicator stopped driving");

   lock_cause_a: assert property (
      @(posedge ref_clk_in) disable iff (!ref_rstn)
      $fell(lock_n_out) |-> $past(serial_lock)
         && $past(hold_cnt) == srd_pkg::LOCK_HOLD_RCLKS)
      else $error("lock indicator fell without serial lock");

   lock_loss_a: assert property (
      @(posedge ref_clk_in) disable iff (!ref_rstn)
      !lock_n_out && !serial_lock |=> lock_n_out ##1 !follow_tx)
      else $error("lock loss not reported");

   strobe_edge_a: assert property (
      @(posedge ref_clk_in) disable iff (!ref_rstn)
      parallel_word_out != $past(parallel_word_out) |->
         $past(sy_sync[srd_pkg::SY_SEL]) ? $rose(recovered_clk_out)
                                         : $fell(recovered_clk_out))
      else $error("word changed away from selected strobe edge");

   tx_clock_a: assert property (
      @(posedge ref_clk_in) disable iff (!ref_rstn)
      $past(follow_tx) && $rose(recovered_clk_out) |-> $past(word_evt))
      else $error("locked clock not driven by transmitter words");

   local_clock_a: assert property (
      @(posedge ref_clk_in) disable iff (!ref_rstn)
      lock_n_out && local_tick |=> recovered_clk_out ##1
         recovered_clk_out)
      else $error("local recovered clock not running");

   local_source_a: assert property (
      @(posedge ref_clk_in) disable iff (!ref_rstn)
      !$past(follow_tx) && $rose(recovered_clk_out) |-> $past(local_tick))
      else $error("unlocked clock not driven by local divider");

   word_hold_a: assert property (
      @(posedge ref_clk_in) disable iff (!ref_rstn)
      !strobe |=> $stable(parallel_word_out))
      else $error("word changed without a strobe");

   clk_high_a: assert property (
      @(posedge ref_clk_in) disable iff (!ref_rstn)
      $rose(recovered_clk_out) |-> recovered_clk_out [*8])
      else $error("recovered clock high phase too short");

   lock_source_a: assert property (
      @(posedge ref_clk_in) disable iff (!ref_rstn)
      !lock_n_out |-> $past(serial_lock))
      else $error("lock indicator low without serial lock");

   hold_high_a: assert property (
      @(posedge ref_clk_in) disable iff (!ref_rstn)
      lock_n_out && hold_cnt != srd_pkg::LOCK_HOLD_RCLKS |=> lock_n_out)
      else $error("lock indicator fell before hold time");

   settle_count_a: assert property (
      @(posedge ref_clk_in) disable iff (!ref_rstn)
      !ref_ready |=> pll_cnt == $past(pll_cnt) + 12'h001)
      else $error("reference settle counter skipped a cycle");

endmodule // srd_top

//--- srd_serializer.sv
// Purpose: behavioural serializer feeding framed 12-bit serial words.
// Assumes: one bit per rising bit_clk_in edge; no reset, starts idle.
// Notes: idle line sits high, as a fail-safe input would pull it.
`timescale 1ns/100ps

module srd_serializer (
   input wire logic bit_clk_in,
   input wire logic [2:0] mode_in,
   input wire logic [9:0] word_in,
   output logic serial_in_pos_out,
   output logic serial_in_neg_out,
   output logic [15:0] frames_out
);
   logic [3:0] bit_pos;
   logic [11:0] shreg;
   logic [14:0] lfsr;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [14:0] step10(input logic [14:0] s);
      for (int k = 0; k < 10; k++) begin
         s = {s[13:0], s[14] ^ s[13]};
      end
      return s;
   endfunction

   initial begin
      bit_pos = 4'h0;
      shreg = 12'hFFF;
      frames_out = 16'h0000;
      lfsr = 15'h1ACE;
   end

   // mode is taken only at a frame boundary so frames go out whole
   always @(posedge bit_clk_in) begin
      if (bit_pos == 4'hB) begin
         bit_pos <= 4'h0;
         frames_out <= frames_out + 16'h0001;
         lfsr <= step10(lfsr);
         case (mode_in)
            3'h1: shreg <= 12'h03F;
            3'h2: shreg <= {1'b0, word_in, 1'b1};
            3'h3: shreg <= {1'b0, lfsr[9:0], 1'b1};
            3'h4: shreg <= 12'h000; // no boundary edge: deliberate fault
            default: shreg <= 12'hFFF;
         endcase
      end else begin
         bit_pos <= bit_pos + 4'h1;
         shreg <= {1'b1, shreg[11:1]};
      end
   end

   assign serial_in_pos_out = shreg[0];
   assign serial_in_neg_out = ~shreg[0];
endmodule // srd_serializer

//--- srd_top_test.sv
// Purpose: self-checking bench for the deserialiser back end.
// Assumes: 125 MHz reference, 12 ns link bit clock, inputs on falling edge.
// Notes: a monitor tracks recovered clock edges and word update timing.
`timescale 1ns/100ps

module srd_top_test;
   logic ref_clk_in, rstn_in, sleep_n_in, bit_clk_in;
   logic strobe_rise_sel_in, out_enable_in, ser_pos, ser_neg;
   logic [9:0] parallel_word_out, last_word, tx_word;
   logic parallel_word_oe_out, recovered_clk_out, recovered_clk_oe_out;
   logic lock_n_out, lock_n_oe_out, last_rclk, chk_strobe;
   logic [2:0] tx_mode;
   logic [15:0] tx_frames;
   logic [9:0] words [6] = '{10'h001, 10'h200, 10'h155, 10'h2AA, 10'h3FF,
                             10'h000};
   int fails, checks, rclk_rises, sel_edges, r0, n;

   srd_top i_srd_top (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
      .sleep_n_in(sleep_n_in), .bit_clk_in(bit_clk_in),
      .serial_in_pos_in(ser_pos), .serial_in_neg_in(ser_neg),
      .strobe_rise_sel_in(strobe_rise_sel_in),
      .out_enable_in(out_enable_in), .parallel_word_out(parallel_word_out),
      .parallel_word_oe_out(parallel_word_oe_out),
      .recovered_clk_out(recovered_clk_out),
      .recovered_clk_oe_out(recovered_clk_oe_out),
      .lock_n_out(lock_n_out), .lock_n_oe_out(lock_n_oe_out));

   srd_serializer i_srd_serializer (.bit_clk_in(bit_clk_in),
      .mode_in(tx_mode), .word_in(tx_word), .serial_in_pos_out(ser_pos),
      .serial_in_neg_out(ser_neg), .frames_out(tx_frames));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk_in = 1'b0;
      forever #4 ref_clk_in = ~ref_clk_in;
   end

   // offset so link edges never share a time step with reference edges
   initial begin
      bit_clk_in = 1'b0;
      #3;
      forever #6 bit_clk_in = ~bit_clk_in;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("counts: checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                        input string what);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t %s: saw %h expected %h", $time, what, seen,
                  exp);
      end
   endtask

   task automatic timeout(input string what);
      fails++;
      $display("[ERR] %0t wait for %s timed out", $time, what);
      report_and_stop();
   endtask

   task automatic tick(input int k);
      repeat (k) @(negedge ref_clk_in);
   endtask

   task automatic wait_lock(input logic lvl, input int bound);
      for (int i = 0; i < bound && lock_n_out !== lvl; i++) tick(1);
      if (lock_n_out !== lvl) timeout("lock level");
   endtask

   task automatic wait_frames(input int k);
      logic [15:0] f0;
      f0 = tx_frames;
      for (int i = 0; i < k * 40 && 16'(tx_frames - f0) < k; i++) tick(1);
      if (16'(tx_frames - f0) < k) timeout("frames");
   endtask

   task automatic wait_sel(input int k);
      int s0;
      s0 = sel_edges;
      for (int i = 0; i < k * 40 && sel_edges - s0 < k; i++) tick(1);
      if (sel_edges - s0 < k) timeout("strobe edges");
   endtask

   // after any reset release: data and clock pins float and lock_n_out drives high until the reference settles
   task automatic restart_check;
      tick(4);
      check(16'({lock_n_oe_out, parallel_word_oe_out, recovered_clk_oe_out,
         lock_n_out}), 16'h0009, "restart outputs");
      n = 4;
      while (parallel_word_oe_out !== 1'b1 && n < 2200) begin
         tick(1);
         n++;
      end
      if (n >= 2200) timeout("reference settle");
      check(16'(n >= 2048), 16'h0001, "settle length");
      r0 = rclk_rises;
      tick(40);
      check(16'(rclk_rises - r0 >= 2), 16'h0001, "local clock");
      check(16'({recovered_clk_oe_out, lock_n_out}), 16'h0003,
            "unlocked outputs");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // word must change exactly with the selected recovered clock edge
   always @(negedge ref_clk_in) begin
      if (recovered_clk_out === strobe_rise_sel_in &&
          last_rclk === !strobe_rise_sel_in)
         sel_edges++;
      if (recovered_clk_out === 1'b1 && last_rclk === 1'b0)
         rclk_rises++;
      if (chk_strobe && parallel_word_out !== last_word) begin
         check(16'({last_rclk, recovered_clk_out}),
               16'({!strobe_rise_sel_in, strobe_rise_sel_in}),
               "word update edge");
      end
      last_rclk = recovered_clk_out;
      last_word = parallel_word_out;
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      fails = 0;
      checks = 0;
      rclk_rises = 0;
      sel_edges = 0;
      rstn_in = 1'b0;
      sleep_n_in = 1'b1;
      strobe_rise_sel_in = 1'b1;
      out_enable_in = 1'b1;
      tx_mode = 3'h0;
      tx_word = 10'h000;
      chk_strobe = 1'b0;
      tick(6);
      check(16'({lock_n_oe_out, parallel_word_oe_out, recovered_clk_oe_out,
         lock_n_out}), 16'h0001, "reset outputs");
      rstn_in = 1'b1;
      restart_check();
      $display("test init done");

      tx_mode = 3'h1;
      r0 = rclk_rises;
      wait_lock(1'b0, 800);
      check(16'(rclk_rises - r0 <= 42), 16'h0001, "sync lock time");
      $display("test sync lock done");

      for (int s = 1; s >= 0; s--) begin
         chk_strobe = 1'b0;
         strobe_rise_sel_in = s[0];
         tx_mode = 3'h2;
         tick(2);
         chk_strobe = 1'b1;
         foreach (words[i]) begin
            tx_word = words[i];
            // rise strobe shows each word one frame late
            wait_frames(4);
            check(16'(parallel_word_out), 16'(words[i]), "word");
         end
      end
      check(16'(lock_n_out), 16'h0000, "lock on data");
      $display("test words done");

      out_enable_in = 1'b0;
      tick(5);
      check(16'({lock_n_oe_out, parallel_word_oe_out, recovered_clk_oe_out,
         lock_n_out}), 16'h0008, "outputs disabled");
      repeat (6) begin
         out_enable_in = ~out_enable_in;
         tick(1);
      end
      out_enable_in = 1'b1;
      wait_frames(2);
      check(16'({lock_n_oe_out, parallel_word_oe_out, recovered_clk_oe_out,
         lock_n_out}), 16'h000E, "outputs back");
      check(16'(parallel_word_out), 16'(words[5]), "word kept");
      $display("test enable done");

      chk_strobe = 1'b0;
      tx_word = 10'h007;
      tx_mode = 3'h4;
      wait_frames(1);
      tx_mode = 3'h2;
      wait_lock(1'b1, 100);
      r0 = rclk_rises;
      wait_lock(1'b0, 800);
      check(16'(rclk_rises - r0 >= 2), 16'h0001, "unlock hold");
      wait_sel(2);
      check(16'(parallel_word_out), 16'h0007, "valid after relock");
      $display("test relock done");

      sleep_n_in = 1'b0;
      tx_mode = 3'h0;
      #1;
      check(16'({lock_n_oe_out, parallel_word_oe_out, recovered_clk_oe_out}),
            16'h0000, "sleep floats");
      tick(3);
      sleep_n_in = 1'b1;
      restart_check();
      tick(200);
      check(16'(lock_n_out), 16'h0001, "no lock on idle line");
      tx_mode = 3'h3;
      wait_lock(1'b0, 4000);
      check(16'(lock_n_out), 16'h0000, "lock on varied data");
      $display("test sleep done");
      report_and_stop();
   end
endmodule // srd_top_test
